// ### air_regs.sv
/*
  air_regs: two 8-bit routing registers for the right ADC mixer,
  reached over an Avalon-MM slave with waitrequest.
  assumes: synchronous bus master on mclk, asynchronous active-low
  reset, analog controls taken from the outputs below.
*/
// Functional notes
// - second_right_line_input bit 7 selects differential mode
// - second_right_line_input codes 0, 4, 8 give 0/-6/-12 dB
// - second_right_line_input code 1111 disconnects, also reset
// - second_right_line_input bit 2 enables weak common-mode bias
// - second_right_line_input bits 1:0 read-only zero
// - first_left_line_input bit 7 selects differential mode
// - first_left_line_input codes 0..8 step -1.5 dB
// - valid first_left_line_input code connects the input
// - first_left_line_input code 1111 disconnects, also reset
// - first_left_line_input bits 2:0 read-only zero
`timescale 1ns/100ps
module air_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   second_right_line_input_diff,
  output logic [3:0]             second_right_line_input_level,
  output logic                   second_right_line_input_connect,
  output logic                   right_weak_bias,
  output logic                   first_left_line_input_diff,
  output logic [3:0]             first_left_line_input_level,
  output logic                   first_left_line_input_connect
);

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    AIR_IDLE = 2'b01,
    AIR_ACK  = 2'b10
  } air_state_e;

  air_state_e state_reg;
  air_state_e state_next;

  logic       l2_diff_reg;
  logic [3:0] l2_level_reg;
  logic       wbias_reg;
  logic       l1_diff_reg;
  logic [3:0] l1_level_reg;
  logic [31:0] rdata_reg;
  logic        wait_reg;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire        req_w    = avs_read | avs_write;
  wire        hit_l2   = avs_address == ADDR_W'(air_pkg::OFS_SECOND_RIGHT_LINE_INPUT_ROUTE);
  wire        hit_l1   = avs_address == ADDR_W'(air_pkg::OFS_FIRST_LEFT_LINE_INPUT_ROUTE);
  wire        fire     = (state_reg == AIR_ACK) && req_w;
  wire        wr_l2    = fire && avs_write && hit_l2 && avs_byteenable[0];
  wire        wr_l1    = fire && avs_write && hit_l1 && avs_byteenable[0];
  wire [7:0]  wd       = avs_writedata[7:0];
  // reserved low bits never stored, read back as zero
  wire [7:0]  rd_l2    = {l2_diff_reg, l2_level_reg, wbias_reg, 2'h0};
  wire [7:0]  rd_l1    = {l1_diff_reg, l1_level_reg, 3'h0};
  wire [7:0]  rd_sel   = hit_l2 ? rd_l2 : (hit_l1 ? rd_l1 : 8'h00);
  wire [3:0]  l2_lvl_n = wd[air_pkg::LEVEL_MSB:air_pkg::LEVEL_LSB];
  wire [3:0]  l1_lvl_n = wd[air_pkg::LEVEL_MSB:air_pkg::LEVEL_LSB];

  // ---------------------------------------------------------------
  // handshake: one wait cycle, then answer
  // ---------------------------------------------------------------
  always_comb
  begin
    case (state_reg)
      AIR_IDLE: state_next = req_w ? AIR_ACK : AIR_IDLE;
      AIR_ACK:  state_next = AIR_IDLE;
      default:  state_next = AIR_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= AIR_IDLE;
      wait_reg  <= 1'h1;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg  <= !(state_reg == AIR_IDLE && req_w);
      if (state_reg == AIR_IDLE && avs_read)
        rdata_reg <= {24'h00_0000, rd_sel};
    end
  end

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      l2_diff_reg  <= air_pkg::DIFF_RST;
      l2_level_reg <= air_pkg::LEVEL_RST;
      wbias_reg    <= air_pkg::WBIAS_RST;
      l1_diff_reg  <= air_pkg::DIFF_RST;
      l1_level_reg <= air_pkg::LEVEL_RST;
    end
    else
    begin
      if (wr_l2)
      begin
        l2_diff_reg  <= wd[air_pkg::DIFF_BIT];
        l2_level_reg <= l2_lvl_n;
        wbias_reg    <= wd[air_pkg::WBIAS_BIT];
      end
      if (wr_l1)
      begin
        l1_diff_reg  <= wd[air_pkg::DIFF_BIT];
        l1_level_reg <= l1_lvl_n;
      end
    end
  end

  // ---------------------------------------------------------------
  // analog-side controls, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      second_right_line_input_diff     <= air_pkg::DIFF_RST;
      second_right_line_input_level    <= air_pkg::LEVEL_RST;
      second_right_line_input_connect  <= 1'h0;
      right_weak_bias <= air_pkg::WBIAS_RST;
      first_left_line_input_diff     <= air_pkg::DIFF_RST;
      first_left_line_input_level    <= air_pkg::LEVEL_RST;
      first_left_line_input_connect  <= 1'h0;
    end
    else
    begin
      second_right_line_input_diff     <= l2_diff_reg;
      second_right_line_input_level    <= l2_level_reg;
      second_right_line_input_connect  <= l2_level_reg != air_pkg::LEVEL_OFF;
      right_weak_bias <= wbias_reg;
      first_left_line_input_diff     <= l1_diff_reg;
      first_left_line_input_level    <= l1_level_reg;
      first_left_line_input_connect  <= l1_level_reg != air_pkg::LEVEL_OFF;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  ack_timing_a: assert property
    (req_w && state_reg == AIR_IDLE |=>
     !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest timing wrong");

  wait_idle_a: assert property
    (state_reg == AIR_IDLE && !req_w |=>
     avs_waitrequest)
    else $error("waitrequest low without request");

  wait_one_a: assert property
    (!avs_waitrequest |=>
     avs_waitrequest)
    else $error("waitrequest low too long");

  state_onehot_a: assert property
    ($onehot(state_reg)
     )
    else $error("handshake state not one-hot");

  wr_answer_a: assert property
    (wr_l2 || wr_l1 |->
     !avs_waitrequest)
    else $error("write landed without answer");

  // ---------------------------------------------------------------
  // assertions: second_right_line_input
  // ---------------------------------------------------------------
  l2_diff_follow_a: assert property
    (wr_l2 |-> ##2
     second_right_line_input_diff == $past(wd[air_pkg::DIFF_BIT], 2))
    else $error("second_right_line_input mode not applied");

  l2_level_a: assert property
    (wr_l2 |-> ##2
     second_right_line_input_level == $past(l2_lvl_n, 2))
    else $error("second_right_line_input level not applied");

  l2_off_a: assert property
    (second_right_line_input_connect |->
     $past(l2_level_reg) != air_pkg::LEVEL_OFF)
    else $error("second_right_line_input connected at code 1111");

  wbias_follow_a: assert property
    (wr_l2 |-> ##2
     right_weak_bias == $past(wd[air_pkg::WBIAS_BIT], 2))
    else $error("weak bias not applied");

  l2_rsvd_zero_a: assert property
    (fire && avs_read && hit_l2 |->
     avs_readdata[1:0] == 2'h0)
    else $error("second_right_line_input reserved bits nonzero");

  l2_diff_hold_a: assert property
    (!wr_l2 |=>
     l2_diff_reg == $past(l2_diff_reg))
    else $error("second_right_line_input mode changed without write");

  l2_level_hold_a: assert property
    (!wr_l2 |=>
     l2_level_reg == $past(l2_level_reg))
    else $error("second_right_line_input level changed without write");

  wbias_hold_a: assert property
    (!wr_l2 |=>
     wbias_reg == $past(wbias_reg))
    else $error("weak bias changed without write");

  l2_connect_on_a: assert property
    (l2_level_reg != air_pkg::LEVEL_OFF |=>
     second_right_line_input_connect)
    else $error("second_right_line_input not connected");

  l2_rd_mode_a: assert property
    (fire && avs_read && hit_l2 |->
     avs_readdata[air_pkg::DIFF_BIT] == l2_diff_reg)
    else $error("second_right_line_input mode read wrong");

  l2_rd_bias_a: assert property
    (fire && avs_read && hit_l2 |->
     avs_readdata[air_pkg::WBIAS_BIT] == wbias_reg)
    else $error("weak bias read wrong");

  // ---------------------------------------------------------------
  // assertions: first_left_line_input
  // ---------------------------------------------------------------
  l1_diff_follow_a: assert property
    (wr_l1 |-> ##2
     first_left_line_input_diff == $past(wd[air_pkg::DIFF_BIT], 2))
    else $error("first_left_line_input mode not applied");

  l1_level_a: assert property
    (wr_l1 |-> ##2
     first_left_line_input_level == $past(l1_lvl_n, 2))
    else $error("first_left_line_input level not applied");

  l1_connect_a: assert property
    (wr_l1 && l1_lvl_n <= air_pkg::LEVEL_MAXOK |-> ##2
     first_left_line_input_connect)
    else $error("valid first_left_line_input code not connected");

  l1_off_a: assert property
    (wr_l1 && l1_lvl_n == air_pkg::LEVEL_OFF |-> ##2
     !first_left_line_input_connect)
    else $error("first_left_line_input connected at code 1111");

  l1_rsvd_zero_a: assert property
    (fire && avs_read && hit_l1 |->
     avs_readdata[2:0] == 3'h0)
    else $error("first_left_line_input reserved bits nonzero");

  l1_diff_hold_a: assert property
    (!wr_l1 |=>
     l1_diff_reg == $past(l1_diff_reg))
    else $error("first_left_line_input mode changed without write");

  l1_level_hold_a: assert property
    (!wr_l1 |=>
     l1_level_reg == $past(l1_level_reg))
    else $error("first_left_line_input level changed without write");

  l1_off_reg_a: assert property
    (l1_level_reg == air_pkg::LEVEL_OFF |=>
     !first_left_line_input_connect)
    else $error("first_left_line_input connected while off");

  l1_rd_level_a: assert property
    (fire && avs_read && hit_l1 |->
     avs_readdata[air_pkg::LEVEL_MSB:air_pkg::LEVEL_LSB] == l1_level_reg)
    else $error("first_left_line_input level read wrong");

  l1_rd_mode_a: assert property
    (fire && avs_read && hit_l1 |->
     avs_readdata[air_pkg::DIFF_BIT] == l1_diff_reg)
    else $error("first_left_line_input mode read wrong");

  // ---------------------------------------------------------------
  // assertions: read path and refused writes
  // ---------------------------------------------------------------
  rd_upper_zero_a: assert property
    (fire && avs_read |->
     avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read bits nonzero");

  unmapped_rd_a: assert property
    (fire && avs_read && !hit_l2 && !hit_l1 |->
     avs_readdata == 32'h0000_0000)
    else $error("unmapped read nonzero");

  be_ignore_a: assert property
    (fire && avs_write && !avs_byteenable[0] |=>
     l2_level_reg == $past(l2_level_reg) && l1_level_reg == $past(l1_level_reg))
    else $error("masked write changed a level");

  readdata_hold_a: assert property
    (!(state_reg == AIR_IDLE && avs_read) |=>
     $stable(avs_readdata))
    else $error("read data changed without read");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  wr_l2_c: cover property (wr_l2 ##1 fire && avs_read && hit_l2);
  wr_l1_c: cover property (wr_l1 && l1_lvl_n == 4'h8);
  diff_c:  cover property (second_right_line_input_diff && first_left_line_input_diff);
  bias_c:  cover property (right_weak_bias && second_right_line_input_connect);

endmodule

// ### air_pkg.sv
/*
  air_pkg: offsets, field positions, reset values and codes of the
  right-ADC input routing register bank.
  assumes: used by air_regs only; all names written air_pkg::name.
*/
package air_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_SECOND_RIGHT_LINE_INPUT_ROUTE = 8'h17;
  localparam logic [7:0] OFS_FIRST_LEFT_LINE_INPUT_ROUTE = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int DIFF_BIT   = 7;
  localparam int LEVEL_MSB  = 6;
  localparam int LEVEL_LSB  = 3;
  localparam int WBIAS_BIT  = 2;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic       DIFF_RST    = 1'h0;
  localparam logic [3:0] LEVEL_RST   = 4'hF;
  localparam logic       WBIAS_RST   = 1'h0;
  localparam logic [3:0] LEVEL_OFF   = 4'hF;
  localparam logic [3:0] LEVEL_MAXOK = 4'h8;
  localparam logic [3:0] LVL_0DB     = 4'h0;
  localparam logic [3:0] LVL_6DB     = 4'h4;
  localparam logic [3:0] LVL_12DB    = 4'h8;

  // ---------------------------------------------------------------
  // bus answer timing: waitrequest low in the cycle after the request
  // ---------------------------------------------------------------
  localparam int ACK_CYCLES = 1;

endpackage

// ### air_tb.sv
/*
  air_tb: self-checking bench for the right-ADC routing register bank.
  assumes: air_regs with one wait cycle per request, mclk 10 MHz.
*/
`timescale 1ns/100ps
module testbench;
  // ---------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [12:0] ana;
  logic [7:0]  e2;
  logic [7:0]  e1;
  logic [7:0]  v;
  logic [31:0] q[$];
  int          errors = 0;
  int          cmp_count = 0;
  int          seed_val;
  air_regs u_air_regs (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .second_right_line_input_diff(ana[12]), .second_right_line_input_level(ana[11:8]),
    .second_right_line_input_connect(ana[7]), .right_weak_bias(ana[6]), .first_left_line_input_diff(ana[5]),
    .first_left_line_input_level(ana[4:1]), .first_left_line_input_connect(ana[0]));
  always #50 mclk = ~mclk;
  // ---------------------------------------------------------------
  // checks and bus tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      errors++;
      conclude();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00, 4'hF);
  endtask
  task automatic outs();
    @(negedge mclk);
    chk({19'h0, ana}, {19'h0, e2[7], e2[6:3], e2[6:3] != 4'hF, e2[2],
                       e1[7], e1[6:3], e1[6:3] != 4'hF});
  endtask
  // read monitor: oldest note against each read answer
  always @(posedge mclk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      if (q.size() == 0)
        chk(avs_readdata, 32'hFFFF_FFFF);
      else
        chk(avs_readdata, q.pop_front());
    end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    seed_val = $urandom(32'h2395f35f);
    e2 = 8'h78;
    e1 = 8'h78;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    outs();
    @(posedge mclk);
    rd(8'h17, 8'h78);
    rd(8'h18, 8'h78);
    for (int i = 0; i < 4; i++)
    begin
      v = $urandom;
      v[6:3] = (i == 3) ? 4'hF : 4'(i * 4);
      v[1:0] = 2'b00;
      bus(1'b1, 8'h17, v, 4'(1 | $urandom));
      e2 = {v[7:2], 2'b00};
      outs();
      @(posedge mclk);
      rd(8'h17, e2);
    end
    for (int i = 0; i < 10; i++)
    begin
      v = $urandom;
      v[6:3] = (i == 9) ? 4'hF : 4'(i);
      v[2:0] = 3'b000;
      bus(1'b1, 8'h18, v, 4'(1 | $urandom));
      e1 = {v[7:3], 3'b000};
      outs();
      @(posedge mclk);
      rd(8'h18, e1);
    end
    bus(1'b1, 8'h19, 8'hFF, 4'hF);
    rd(8'h19, 8'h00);
    bus(1'b1, 8'h17, 8'hA0, 4'hE);
    bus(1'b1, 8'h18, 8'hA0, 4'hE);
    rd(8'h17, e2);
    rd(8'h18, e1);
    outs();
    repeat (2) @(posedge mclk);
    conclude();
  end
endmodule
